// [verilog/sbrs_pkg.sv]
// Package: constants and types for the self-boot ROM sequencer
package sbrs_pkg;
  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int           WORD_W     = 18;
  localparam int           ADDR_W     = 10;
  localparam int           ROM_DEPTH  = 1024;
  localparam int           TAG_HI     = 17;
  localparam int           TAG_LO     = 16;
  localparam int           PAYLOAD_W  = 16;
  localparam logic [1:0]   TAG_DATA   = 2'h0;
  localparam logic [1:0]   TAG_CMD    = 2'h1;
  localparam logic [1:0]   TAG_LAST   = 2'h2;
  localparam logic [1:0]   TAG_JUMP   = 2'h3;
  localparam logic [9:0]   ADDR_END   = 10'h3FF;
  localparam logic [17:0]  END_WORD   = 18'h303FF;
  // ----------------------------------------------------------------
  // Host commands and timing
  // ----------------------------------------------------------------
  localparam logic [7:0]   CMD_BOOT   = 8'h41;
  localparam logic [7:0]   CMD_RESET  = 8'h4F;
  localparam int           WAIT_FS    = 2048;
  localparam int           WAIT_W     = 12;
  localparam logic [11:0]  WAIT_LAST  = 12'(WAIT_FS - 1);

  typedef enum logic [1:0] {
    SBRS_IDLE = 2'b00,
    SBRS_WAIT = 2'b01,
    SBRS_RUN  = 2'b10
  } sbrs_state_t;
endpackage

// [verilog/sbrs_word_if.sv]
// Interface: decoded boot word passed to the command emitter
`timescale 1ns/1ps
interface sbrs_word_if;
  logic        valid;
  logic [1:0]  tag;
  logic [15:0] payload;
  modport src (output valid, output tag, output payload);
  modport dst (input valid, input tag, input payload);
endinterface

// [verilog/sbrs_emit.sv]
// Module: drives decoded boot words onto the internal command interface
`timescale 1ns/1ps
module sbrs_emit
  import sbrs_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  rst,
  sbrs_word_if.dst   w,
  output logic       sel_n,
  output logic       strobe,
  output logic       is_cmd,
  output logic [15:0] data
);
  logic        sel_n_ff, nxt_sel_n;
  logic        strobe_ff, nxt_strobe;
  logic        is_cmd_ff, nxt_is_cmd;
  logic [15:0] data_ff, nxt_data;
  logic        last_pend_ff;

  // ----------------------------------------------------------------
  // Next word onto the interface, standard transmission framing
  // ----------------------------------------------------------------
  always_comb begin
    nxt_sel_n  = sel_n_ff;
    nxt_strobe = 1'b0;
    nxt_is_cmd = is_cmd_ff;
    nxt_data   = data_ff;
    // Release first, so a word that follows at once still gets selected
    if (strobe_ff && !is_cmd_ff && last_pend_ff) nxt_sel_n = 1'b1;
    if (w.valid && w.tag != TAG_JUMP) begin
      nxt_strobe = 1'b1;
      nxt_data   = w.payload;
      nxt_is_cmd = (w.tag == TAG_CMD);
      nxt_sel_n  = 1'b0;
    end
  end

  // Remembers whether the word on the interface closes its transfer
  always_ff @(posedge clk) begin
    if (rst) last_pend_ff <= 1'b0;
    else if (w.valid && w.tag != TAG_JUMP) last_pend_ff <= (w.tag == TAG_LAST);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_n_ff  <= 1'b1;
      strobe_ff <= 1'b0;
      is_cmd_ff <= 1'b0;
      data_ff   <= 16'h0000;
    end else begin
      sel_n_ff  <= nxt_sel_n;
      strobe_ff <= nxt_strobe;
      is_cmd_ff <= nxt_is_cmd;
      data_ff   <= nxt_data;
    end
  end

  assign sel_n  = sel_n_ff;
  assign strobe = strobe_ff;
  assign is_cmd = is_cmd_ff;
  assign data   = data_ff;

  // Select goes high right after a final word, unless another word follows at once
  last_release_a: assert property (@(posedge clk) disable iff (rst)
    (strobe_ff && last_pend_ff && !is_cmd_ff && !(w.valid && w.tag != TAG_JUMP)) |=> sel_n_ff)
    else $error("select not released after final word");
endmodule // sbrs_emit

// [verilog/sbrs_top.sv]
// Module: self-boot ROM sequencer top level
`timescale 1ns/1ps

module sbrs_top
  import sbrs_pkg::*;
(
  input  wire logic                       CLK,
  input  wire logic                       RST,
  input  wire logic                       BOOT_STRAP,
  input  wire logic [1:0]                 START_SLOT,
  input  wire logic                       HOST_CMD_VALID,
  input  wire logic [7:0]                 HOST_CMD_CODE,
  input  wire logic [sbrs_pkg::ADDR_W-1:0] HOST_BOOT_ADDR,
  input  wire logic                       HOST_CMD_OK,
  input  wire logic                       HOST_SERIAL_IN_I,
  input  wire logic                       TWO_WIRE_MODE,
  input  wire logic                       ROM_WE,
  input  wire logic [sbrs_pkg::ADDR_W-1:0] ROM_WADDR,
  input  wire logic [sbrs_pkg::WORD_W-1:0] ROM_WDATA,
  output logic                            BOOT_BUSY,
  output logic                            IF_SEL_N,
  output logic                            IF_STROBE,
  output logic                            IF_IS_CMD,
  output logic [15:0]                     IF_DATA,
  output logic                            HOST_SERIAL_IN_O,
  output logic                            HOST_SERIAL_IN_OE,
  output logic                            HOST_ACK_SUPPRESS,
  output logic                            CMD_DONE_FLAG
);
  import sbrs_pkg::*;

  // ----------------------------------------------------------------
  // Boot ROM storage
  // ----------------------------------------------------------------
  logic [WORD_W-1:0] autoload_rom [ROM_DEPTH];
  logic [WORD_W-1:0] rom_q;
  logic [ADDR_W-1:0] ptr_ff, nxt_ptr;

  // Image load port; contents stand in for the mask ROM
  always_ff @(posedge CLK) begin
    if (ROM_WE) autoload_rom[ROM_WADDR] <= ROM_WDATA;
  end
  assign rom_q = autoload_rom[ptr_ff];

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  sbrs_state_t       state_ff, nxt_state;
  logic [WAIT_W-1:0] wait_ff, nxt_wait;
  logic              armed_ff, nxt_armed;
  logic              host_boot;
  logic              word_go;

  sbrs_word_if wif ();

  // Slot pins map directly onto the low address bits
  function automatic logic [ADDR_W-1:0] slot_addr(input logic [1:0] s);
    slot_addr = {8'h00, s};
  endfunction

  assign host_boot = HOST_CMD_VALID && (HOST_CMD_CODE == CMD_BOOT);

  // Next-state: reset wait, host start, word walk
  always_comb begin
    nxt_state = state_ff;
    nxt_ptr   = ptr_ff;
    nxt_wait  = wait_ff;
    nxt_armed = 1'b0;
    word_go   = 1'b0;
    if (armed_ff && BOOT_STRAP) begin
      // Strap caught on the first clock after reset release
      nxt_state = SBRS_WAIT;
      nxt_wait  = '0;
      nxt_ptr   = slot_addr(START_SLOT);
    end
    if (host_boot) begin
      // Host boot overrides any wait or run in progress
      nxt_state = SBRS_RUN;
      nxt_ptr   = HOST_BOOT_ADDR;
    end else begin
      unique case (state_ff)
        SBRS_IDLE: ;
        SBRS_WAIT: begin
          if (!(armed_ff && BOOT_STRAP)) begin
            if (wait_ff == WAIT_LAST) nxt_state = SBRS_RUN;
            else nxt_wait = wait_ff + 12'h001;
          end
        end
        SBRS_RUN: begin
          word_go = 1'b1;
          if (ptr_ff == ADDR_END) begin
            nxt_state = SBRS_IDLE;
            word_go   = 1'b0;
          end else if (rom_q[TAG_HI:TAG_LO] == TAG_JUMP) begin
            nxt_ptr = rom_q[ADDR_W-1:0];
          end else begin
            nxt_ptr = ptr_ff + 10'h001;
          end
        end
        default: nxt_state = SBRS_IDLE;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      state_ff <= SBRS_IDLE;
      ptr_ff   <= 10'h000;
      wait_ff  <= 12'h000;
      armed_ff <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      ptr_ff   <= nxt_ptr;
      wait_ff  <= nxt_wait;
      armed_ff <= nxt_armed;
    end
  end

  // Decoded word toward the emitter
  assign wif.valid   = word_go;
  assign wif.tag     = rom_q[TAG_HI:TAG_LO];
  assign wif.payload = rom_q[PAYLOAD_W-1:0];

  sbrs_emit u_emit (
    .clk    (CLK),
    .rst    (RST),
    .w      (wif),
    .sel_n  (IF_SEL_N),
    .strobe (IF_STROBE),
    .is_cmd (IF_IS_CMD),
    .data   (IF_DATA)
  );

  // ----------------------------------------------------------------
  // Host pin handling and completion flag
  // ----------------------------------------------------------------
  logic busy_ff, nxt_busy;
  logic oe_ff, nxt_oe;
  logic sup_ff, nxt_sup;
  logic done_ff, nxt_done;

  // Data pin driven high in SBRS_RUN only; ack withheld for reset cmd in two-wire mode
  always_comb begin
    nxt_busy = (nxt_state != SBRS_IDLE);
    nxt_oe   = !(nxt_state == SBRS_RUN);
    nxt_sup  = HOST_CMD_VALID && TWO_WIRE_MODE && (HOST_CMD_CODE == CMD_RESET);
    nxt_done = done_ff;
    if (HOST_CMD_VALID) nxt_done = HOST_CMD_OK;
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      busy_ff <= 1'b0;
      oe_ff   <= 1'b1;
      sup_ff  <= 1'b0;
      done_ff <= 1'b0;  // cleared by reset or by a command with HOST_CMD_OK low
    end else begin
      busy_ff <= nxt_busy;
      oe_ff   <= nxt_oe;
      sup_ff  <= nxt_sup;
      done_ff <= nxt_done;
    end
  end

  assign BOOT_BUSY         = busy_ff;
  assign HOST_SERIAL_IN_O  = 1'b1;
  assign HOST_SERIAL_IN_OE = oe_ff;
  assign HOST_ACK_SUPPRESS = sup_ff;
  assign CMD_DONE_FLAG     = done_ff;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  wait_len_a: assert property (@(posedge CLK) disable iff (RST)
    (state_ff == SBRS_WAIT && wait_ff == WAIT_LAST && !host_boot && !armed_ff) |=> state_ff == SBRS_RUN)
    else $error("wait did not end at its count");
  end_stop_a: assert property (@(posedge CLK) disable iff (RST)
    (state_ff == SBRS_RUN && ptr_ff == ADDR_END && !host_boot) |=> state_ff == SBRS_IDLE)
    else $error("boot not ended at top address");
  host_start_a: assert property (@(posedge CLK) disable iff (RST)
    host_boot |=> (state_ff == SBRS_RUN && ptr_ff == $past(HOST_BOOT_ADDR)))
    else $error("host boot did not start at once");
  strap_slot_a: assert property (@(posedge CLK) disable iff (RST)
    (armed_ff && BOOT_STRAP && !host_boot) |=> (state_ff == SBRS_WAIT && ptr_ff == {8'h00, $past(START_SLOT)}))
    else $error("strap boot start slot wrong");
  jump_take_a: assert property (@(posedge CLK) disable iff (RST)
    (word_go && rom_q[TAG_HI:TAG_LO] == TAG_JUMP && !host_boot) |=> ptr_ff == $past(rom_q[ADDR_W-1:0]))
    else $error("jump address not loaded");
  step_one_a: assert property (@(posedge CLK) disable iff (RST)
    (word_go && rom_q[TAG_HI:TAG_LO] != TAG_JUMP && !host_boot) |=> ptr_ff == $past(ptr_ff) + 10'h001)
    else $error("pointer did not advance by one");
  pin_high_a: assert property (@(posedge CLK) disable iff (RST)
    state_ff == SBRS_RUN |-> (!HOST_SERIAL_IN_OE && HOST_SERIAL_IN_O))
    else $error("data pin not held high in boot");
  done_track_a: assert property (@(posedge CLK) disable iff (RST)
    HOST_CMD_VALID |=> CMD_DONE_FLAG == $past(HOST_CMD_OK))
    else $error("completion flag wrong");
  ack_sup_a: assert property (@(posedge CLK) disable iff (RST)
    (HOST_CMD_VALID && TWO_WIRE_MODE && HOST_CMD_CODE == CMD_RESET) |=> HOST_ACK_SUPPRESS)
    else $error("reset command ack not withheld");

  reset_boot_c: cover property (@(posedge CLK) state_ff == SBRS_WAIT ##1 state_ff == SBRS_RUN);
  host_boot_c:  cover property (@(posedge CLK) host_boot);
  finish_c:     cover property (@(posedge CLK) state_ff == SBRS_RUN ##1 state_ff == SBRS_IDLE);
endmodule // sbrs_top

// [verification/sbrs_host.sv]
// Host microcontroller model that issues commands to the boot sequencer
`timescale 1ns/1ps
module sbrs_host
  import sbrs_pkg::*;
(
  input  wire logic                        clk,
  output logic                             cmd_valid,
  output logic [7:0]                       cmd_code,
  output logic [sbrs_pkg::ADDR_W-1:0]      boot_addr,
  output logic                             cmd_ok,
  output logic                             two_wire
);
  // Quiet link until the first command
  initial begin
    cmd_valid = 1'b0;
    cmd_code  = 8'h00;
    boot_addr = 10'h000;
    cmd_ok    = 1'b0;
    two_wire  = 1'b0;
  end

  // Only boot and reset codes are sent: no rewrite wait or wrapping write arises
  // One-cycle command pulse; the final acknowledge is never awaited
  task automatic send(input logic [7:0] code, input logic [9:0] addr, input logic ok, input logic tw);
    @(posedge clk);
    #2;
    two_wire  = tw;
    cmd_code  = code;
    boot_addr = addr;
    cmd_ok    = ok;
    cmd_valid = 1'b1;
    @(posedge clk);
    #2;
    cmd_valid = 1'b0;
    // Released fields flip so a stale value is never mistaken for live
    cmd_code  = ~code;
    boot_addr = ~addr;
    cmd_ok    = ~ok;
  endtask
endmodule // sbrs_host

// [verification/test_selfboot_rom_sequencer.sv]
// Testbench: self-checking bench for the self-boot ROM sequencer
`timescale 1ns/1ps
module test_selfboot_rom_sequencer;
  import sbrs_pkg::*;
  logic        CLK = 1'b0;
  logic        RST = 1'b1;
  logic        BOOT_STRAP = 1'b0;
  logic [1:0]  START_SLOT = 2'h0;
  logic        ROM_WE = 1'b0;
  logic [9:0]  ROM_WADDR = 10'h000;
  logic [17:0] ROM_WDATA = 18'h00000;
  wire         cmd_valid, cmd_ok, two_wire, sel_n, strobe, is_cmd, busy, pin_o, pin_oe, ack_sup, done;
  wire  [7:0]  cmd_code;
  wire  [9:0]  boot_addr;
  wire  [15:0] if_data;
  wire         pin_level = pin_oe ? 1'b1 : pin_o;
  logic [16:0] exp_q[$];
  logic [16:0] img[5][4];
  int          err_total = 0;
  int          checked = 0;
  int          n;

  always #25 CLK = ~CLK;

  sbrs_host host (.clk(CLK), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .boot_addr(boot_addr),
                  .cmd_ok(cmd_ok), .two_wire(two_wire));
  sbrs_top dut (.CLK(CLK), .RST(RST), .BOOT_STRAP(BOOT_STRAP), .START_SLOT(START_SLOT),
    .HOST_CMD_VALID(cmd_valid), .HOST_CMD_CODE(cmd_code), .HOST_BOOT_ADDR(boot_addr),
    .HOST_CMD_OK(cmd_ok), .HOST_SERIAL_IN_I(pin_level), .TWO_WIRE_MODE(two_wire), .ROM_WE(ROM_WE),
    .ROM_WADDR(ROM_WADDR), .ROM_WDATA(ROM_WDATA), .BOOT_BUSY(busy), .IF_SEL_N(sel_n),
    .IF_STROBE(strobe), .IF_IS_CMD(is_cmd), .IF_DATA(if_data), .HOST_SERIAL_IN_O(pin_o),
    .HOST_SERIAL_IN_OE(pin_oe), .HOST_ACK_SUPPRESS(ack_sup), .CMD_DONE_FLAG(done));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tick();
    @(posedge CLK);
    #2;
  endtask

  task automatic check(input logic ok, input string msg);
    checked++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask

  task automatic print_verdict();
    if (err_total == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic rom_put(input logic [9:0] a, input logic [17:0] w);
    ROM_WADDR = a;
    ROM_WDATA = w;
    ROM_WE    = 1'b1;
    tick();
  endtask

  // Waits for the first word, then demands the rest back to back
  task automatic run_seq(input int k, input int lo, input int hi);
    for (int i = 0; i < 4; i++) exp_q.push_back(img[k][i]);
    n = 0;
    while (strobe !== 1'b1 && n < 3000) begin
      tick();
      n++;
    end
    check(n >= lo && n <= hi, "first word latency");
    repeat (3) begin
      tick();
      check(strobe === 1'b1, "words not one per cycle");
    end
    repeat (3) tick();
    check(sel_n === 1'b1, "select not released");
    check(busy === 1'b0 && exp_q.size() == 0, "boot did not end");
  endtask

  // Scoreboard: every strobe takes the oldest expected word
  always @(posedge CLK) begin
    if (strobe === 1'b1) begin
      checked++;
      if (exp_q.size() == 0 || {is_cmd, if_data} !== exp_q[0] || sel_n !== 1'b0 || pin_oe !== 1'b0 || pin_o !== 1'b1) begin
        err_total++;
        $display("[FAIL] %0t word or pin mismatch", $time);
      end
      if (exp_q.size() != 0)
        void'(exp_q.pop_front());
    end
  end

  // Watchdog sized well above four reset boots of 2048 cycles
  initial begin
    repeat (20000) @(posedge CLK);
    err_total++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(79));
    repeat (8) tick();
    RST = 1'b0;
    // Image: slots jump to regions, each ends with the end marker
    for (int k = 0; k < 5; k++) begin
      if (k < 4)
        rom_put(10'(k), {TAG_JUMP, 6'h00, 10'(16 * (k + 1))});
      for (int i = 0; i < 4; i++) begin
        img[k][i] = {i == 0, 16'($urandom)};
        rom_put(10'(16 * (k + 1) + i), {(i == 0) ? TAG_CMD : (i == 3) ? TAG_LAST : TAG_DATA, img[k][i][15:0]});
      end
      rom_put(10'(16 * (k + 1) + 4), END_WORD);
    end
    rom_put(ADDR_END, END_WORD);
    ROM_WE = 1'b0;
    repeat (20) tick();
    check(busy === 1'b0 && strobe === 1'b0, "boot without strap");
    // Reset boot from every start slot
    for (int s = 0; s < 4; s++) begin
      RST = 1'b1;
      BOOT_STRAP = 1'b1;
      START_SLOT = 2'(s);
      repeat (8) tick();
      RST = 1'b0;
      tick();
      BOOT_STRAP = 1'b0;
      run_seq(s, 2047, 2056);
    end
    // Host boot at once, in two-wire mode, strap low
    host.send(CMD_BOOT, 10'h050, 1'b1, 1'b1);
    run_seq(4, 0, 3);
    // Reset command refused execution, then a normal boot
    host.send(CMD_RESET, 10'h000, 1'b0, 1'b1);
    n = 0;
    while (ack_sup !== 1'b1 && n < 4) begin
      tick();
      n++;
    end
    check(ack_sup === 1'b1, "ack not suppressed");
    check(done === 1'b0, "done flag after failed command");
    host.send(CMD_BOOT, 10'h010, 1'b1, 1'b0);
    run_seq(0, 0, 3);
    check(done === 1'b1, "done flag after good command");
    print_verdict();
  end
endmodule // test_selfboot_rom_sequencer
